// *** tb/tx_device_model.sv ***
// behavioural model of the transmitter's serial control port
`timescale 1ns/1ns
module tx_device_model #(
  parameter integer SLEEP_N = 60
) (
  input  wire logic aclk,
  input  wire logic enable,
  input  wire logic sclk_line,
  input  wire logic data_line,
  output wire logic clk_oe,
  output wire logic clk_out
);
  logic       en_q = 1'b0;   // enable seen last edge
  logic       ck_q = 1'b0;   // clock line seen last edge
  logic       asleep = 1'b1; // oscillator stopped
  logic       lock = 1'b1;   // transmit lock bit
  logic       pol = 1'b0;    // 0 samples falling edges
  logic       host_clock_output = 1'b0;  // host clock output on
  logic       tx = 1'b0;     // transmit status
  logic       pa = 1'b0;     // amplifier on
  logic [7:0] sh = 8'h00;    // command byte, first bit on top
  logic [5:0] cfg = 6'h00;   // stored transmit setup
  logic [3:0] nb = 4'h0;     // frame edges consumed
  logic [2:0] div = 3'h0;    // crystal divider
  integer     low_n = 0;     // cycles with enable low
  assign clk_oe = tx & host_clock_output;
  assign clk_out = div[2];
  // sample the wires on aclk; the host moves them right after its edges
  always @(posedge aclk) begin
    en_q <= enable;
    ck_q <= sclk_line;
    if (!asleep) div <= div + 3'h1;
    if (enable && !en_q) begin
      low_n <= 0;
      nb <= 4'h0;
      tx <= 1'b0;
      if (asleep) begin
        asleep <= 1'b0;
        lock <= 1'b1;
        pol <= sclk_line;
        if (!data_line) host_clock_output <= 1'b1;
      end
    end else if (!enable) begin
      if (low_n == SLEEP_N) begin
        asleep <= 1'b1;
        lock <= 1'b1;
      end else low_n <= low_n + 1;
      if (!cfg[4]) pa <= 1'b0;
    end else if (sclk_line != ck_q && nb < 4'ha) begin
      if (nb < 4'h8 && sclk_line == pol) begin
        sh <= {sh[6:0], data_line};
        nb <= nb + 4'h1;
      end else if (nb == 4'h8 && sh[7:6] == 2'b11) begin
        tx <= 1'b1;
        cfg <= sh[5:0];
        nb <= 4'h9;
      end else if (nb == 4'h9 && sclk_line == pol) begin
        pa <= !lock;
        nb <= 4'ha;
      end
    end
  end
endmodule // tx_device_model

// *** tb/tx_serial_host_chk.sv ***
// port checker for the serial control host
`timescale 1ns/1ns
module tx_serial_host_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        enable,
  input wire logic        sclk_o,
  input wire logic        sclk_oe_n,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] tgl_q; // clock toggles since enable rose
  logic       sck_q; // clock drive seen last edge
  // count edges per frame; cleared while enable is low
  always @(posedge aclk) begin
    sck_q <= sclk_o;
    if (!aresetn || !enable) tgl_q <= 6'h00;
    else if (sclk_o != sck_q) tgl_q <= tgl_q + 6'h01;
  end
  AST_CODE_BITS: assert property (enable && $changed(sclk_o) && (tgl_q == 6'h00 || tgl_q == 6'h02) |->
    serial_data_pin_o && !serial_data_pin_oe_n) else $error("code bit not one");
  AST_DATA_ON_EDGE: assert property (enable && tgl_q < 6'h10 && $changed(serial_data_pin_o) |->
    $changed(sclk_o)) else $error("data moved off the transfer edge");
  AST_EDGE_COUNT: assert property (enable |-> tgl_q <= 6'h12) else $error("clock edge in stream");
  AST_CLK_DRIVEN: assert property (enable && tgl_q < 6'h12 |-> !sclk_oe_n) else $error("clock released early");
  AST_SPACING: assert property (enable && $changed(sclk_o) |=> $stable(sclk_o)[*3])
    else $error("clock edges too close");
  AST_END_PULSE: assert property ($fell(enable) |-> !enable[*8]) else $error("end pulse short");
  AST_DATA_RELEASE: assert property ($fell(enable) |-> serial_data_pin_oe_n) else $error("data kept");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  cover property (enable && tgl_q == 6'h12);
  cover property ($fell(enable));
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // tx_serial_host_chk

bind tx_serial_host tx_serial_host_chk u_tx_serial_host_chk (.*);

// *** tb/tx_serial_host_tb.sv ***
// self-checking bench for the serial control host
`timescale 1ns/1ns
`include "tx_serial_control_regs.vh"
module tx_serial_host_tb;
  logic        aclk = 0, aresetn = 0, ce = 1, flip = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   enable, sclk_o, sclk_oe_n, serial_data_pin_o, serial_data_pin_oe_n, dev_oe, dev_clk;
  wire logic   sclk_i, serial_data_pin_i;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int errors = 0, compares = 0, cyc = 0;
  // undriven lines wander instead of keeping the last level
  assign sclk_i = !sclk_oe_n ? sclk_o : dev_oe ? dev_clk : flip;
  assign serial_data_pin_i = !serial_data_pin_oe_n ? serial_data_pin_o : flip;
  always #25 aclk = ~aclk;
  tx_serial_host #(.SLEEP_CYCLES(64)) u_tx_serial_host (.*);
  tx_device_model #(.SLEEP_N(60)) u_tx_device_model (.aclk(aclk), .enable(enable), .sclk_line(sclk_i),
    .data_line(serial_data_pin_i), .clk_oe(dev_oe), .clk_out(dev_clk));
  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hang guard and line noise
  always @(posedge aclk) begin
    flip <= ~flip;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR run time expected end seen hang");
      final_report;
    end
  end
  // write: bready only after bvalid shows, to exercise response hold
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(`CTRL_OFS, d, 2'b00);
    chk("ctrl", 32'h0, d);
    rd(`TXCFG_OFS, d, 2'b00);
    chk("txcfg", 32'h0, d);
    rd(`HALF_OFS, d, 2'b00);
    chk("half", 32'h4, d);
    rd(8'h14, d, 2'b10);
    chk("unmapped", 32'h0, d);
    wr(8'h14, 32'hffff_ffff, 2'b10);
    // a stray stop while idle must not cut the first frame short
    wr(`CTRL_OFS, 32'h0000_0002, 2'b00);
  endtask
  // one transmit frame: command byte, stream both levels, end pulse
  task automatic t_frame(input logic [5:0] cfg, input logic [4:0] ctl, input logic pol, input logic mc);
    logic [31:0] d;
    wr(`TXCFG_OFS, {26'h0, cfg}, 2'b00);
    wr(`CTRL_OFS, {27'h0, ctl | 5'h01}, 2'b00);
    do rd(`STATUS_OFS, d, 2'b00); while (d[2:0] !== 3'h5);
    chk("code", 32'h3, u_tx_device_model.sh[7:6]);
    chk("cfg", cfg, u_tx_device_model.cfg);
    chk("tx", 32'h1, u_tx_device_model.tx);
    chk("pol", pol, u_tx_device_model.pol);
    chk("clkout", mc, u_tx_device_model.host_clock_output);
    chk("pa", 32'h0, u_tx_device_model.pa);
    for (int v = 1; v >= 0; v--) begin
      wr(`TXDATA_OFS, v, 2'b00);
      repeat (3) @(posedge aclk);
      chk("stream", v, serial_data_pin_i);
    end
    wr(`CTRL_OFS, {27'h0, (ctl & 5'h1c) | 5'h02}, 2'b00);
    do rd(`STATUS_OFS, d, 2'b00); while (d[2:0] !== 3'h0);
    chk("enable", 32'h0, enable);
  endtask
  // a low clock enable freezes the sleep count; once it runs again the count expires
  task automatic t_sleep;
    logic [31:0] d;
    ce <= 1'b0;
    repeat (120) @(posedge aclk);
    ce <= 1'b1;
    rd(`STATUS_OFS, d, 2'b00);
    chk("frozen_awake", 32'h1, d[3]);
    repeat (80) @(posedge aclk);
    rd(`STATUS_OFS, d, 2'b00);
    chk("awake", 32'h0, d[3]);
    chk("asleep", 32'h1, u_tx_device_model.asleep);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_frame(6'h2a, 5'h00, 1'b0, 1'b0);
    t_sleep;
    t_frame(6'h15, 5'h1c, 1'b1, 1'b1);
    t_frame(6'h3f, 5'h08, 1'b1, 1'b1);
    final_report;
  end
endmodule // tx_serial_host_tb

// *** verilog/sclk_tick.v ***
// half-period tick generator that paces the serial clock made by the host
`timescale 1ns/1ns
module sclk_tick (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [15:0] half,
  output reg         tick
);

  reg [15:0] count_q;  // aclk cycles into the current half period

  // one-cycle tick every half aclk cycles; a zero setting behaves as one
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
      tick    <= 1'b0;
    end else if (ce) begin
      if (count_q + 16'h0001 >= half) begin
        count_q <= 16'h0000;
        tick    <= 1'b1;
      end else begin
        count_q <= count_q + 16'h0001;
        tick    <= 1'b0;
      end
    end
  end

endmodule // sclk_tick

// *** verilog/tx_serial_control_regs.vh ***
// register offsets, field positions, reset values and timing counts of the serial host
`ifndef TX_SERIAL_CONTROL_REGS_VH
`define TX_SERIAL_CONTROL_REGS_VH

// register byte offsets, one aligned word each
`define CTRL_OFS        8'h00
`define TXCFG_OFS       8'h04
`define TXDATA_OFS      8'h08
`define STATUS_OFS      8'h0C
`define HALF_OFS        8'h10

// control register fields
`define CTRL_START_BIT  0
`define CTRL_STOP_BIT   1
`define CTRL_POL_BIT    2
`define CTRL_CLKOUT_BIT 3
`define CTRL_REL_BIT    4
`define CTRL_W          5

// reset values
`define CTRL_RST        5'h00
`define TXCFG_RST       6'h00
`define HALF_RST        16'h0004

// function code of the transmit command, sent high bit first
`define FUNC_TRANSMIT   2'h3

// timing counts in serial clock half periods
`define SETUP_TICKS     4'h2
`define END_TICKS       4'h4

// power-down timer of the device and the slowest crystal it may run from
`define PD_XTAL_CYCLES  65536
`define XTAL_MIN_KHZ    12000
`define ACLK_KHZ        20000

`endif

// *** verilog/tx_serial_host.v ***
// host controller that drives the transmitter serial control port from axi4-lite registers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "tx_serial_control_regs.vh"

module tx_serial_host #(
  parameter integer SLEEP_CYCLES =
    (`PD_XTAL_CYCLES * `ACLK_KHZ + `XTAL_MIN_KHZ - 1) / `XTAL_MIN_KHZ,
  parameter integer ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               enable,
  output reg               sclk_o,
  output reg               sclk_oe_n,
  input  wire              sclk_i,
  output reg               serial_data_pin_o,
  output reg               serial_data_pin_oe_n,
  input  wire              serial_data_pin_i
);

  // controller states
  localparam [2:0] S_IDLE   = 3'h0;  // enable low, waiting for a start
  localparam [2:0] S_SETUP  = 3'h1;  // enable low with wake levels set up
  localparam [2:0] S_CMD    = 3'h2;  // shifting the command byte
  localparam [2:0] S_EXTRA  = 3'h3;  // extra edge after the last bit
  localparam [2:0] S_FIRST  = 3'h4;  // sampling edge with the first data bit
  localparam [2:0] S_STREAM = 3'h5;  // free-running data stream
  localparam [2:0] S_END    = 3'h6;  // enable low pulse closing the frame

  localparam [ADDR_W-1:0] A_CTRL   = `CTRL_OFS;
  localparam [ADDR_W-1:0] A_TXCFG  = `TXCFG_OFS;
  localparam [ADDR_W-1:0] A_TXDATA = `TXDATA_OFS;
  localparam [ADDR_W-1:0] A_STATUS = `STATUS_OFS;
  localparam [ADDR_W-1:0] A_HALF   = `HALF_OFS;
  localparam [31:0]       SLEEP_LAST = SLEEP_CYCLES - 1;

  reg  [2:0]        state_q;       // controller state
  reg  [`CTRL_W-1:0] ctrl_q;       // control bits, start and stop read back as zero
  reg  [5:0]        txcfg_q;       // transmit configuration a5..a0
  reg               txbit_q;       // level put on the data line while streaming
  reg  [15:0]       half_q;        // serial clock half period in aclk cycles
  reg               start_q;       // pending start, held until the idle state takes it
  reg               stop_q;        // pending stop
  reg               awake_q;       // host view: device is out of sleep
  reg               pol_q;         // clock idle level captured by the device at wake
  reg  [7:0]        shift_q;       // command byte, next bit in the top position
  reg  [2:0]        bits_q;        // sampled bits of the command byte
  reg  [3:0]        wait_q;        // half periods left in setup or end pulse
  reg  [31:0]       low_cnt_q;     // aclk cycles with enable low while awake
  reg  [1:0]        sclk_sync_q;   // clock line synchroniser
  reg  [1:0]        data_sync_q;   // data line synchroniser
  reg  [ADDR_W-1:0] awaddr_q;      // captured write address
  reg  [31:0]       wdata_q;       // captured write data
  reg  [3:0]        wstrb_q;       // captured write strobes
  reg               aw_got_q;      // write address held
  reg               w_got_q;       // write data held
  wire              tick;          // half-period pace of the serial clock
  wire              wr_fire;       // both write halves present, response free
  wire              idle_edge;     // clock currently at its idle level

  assign wr_fire   = aw_got_q && w_got_q && !s_axi_bvalid;
  assign idle_edge = (sclk_o == pol_q);

  // serial clock pace; shared by setup, shifting and the end pulse
  sclk_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .half    (half_q),
    .tick    (tick)
  );

  // pin inputs cross two flip-flops before anything looks at them
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_sync_q <= 2'h0;
      data_sync_q <= 2'h0;
    end else if (ce) begin
      sclk_sync_q <= {sclk_sync_q[0], sclk_i};
      data_sync_q <= {data_sync_q[0], serial_data_pin_i};
    end
  end

  // write channel: address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (ce) begin
      // ready stays low while a half is held, so nothing is overwritten
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        // unmapped addresses answer slverr and change nothing
        if (awaddr_q == A_CTRL || awaddr_q == A_TXCFG || awaddr_q == A_TXDATA ||
            awaddr_q == A_STATUS || awaddr_q == A_HALF)
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register contents; start and stop are requests the controller consumes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= `CTRL_RST;
      txcfg_q <= `TXCFG_RST;
      txbit_q <= 1'b0;
      half_q  <= `HALF_RST;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else if (ce) begin
      // a request taken by the controller clears, a new write sets; set wins
      if (state_q == S_IDLE && start_q)
        start_q <= 1'b0;
      // a stop written in idle is dropped, so it cannot cut the next frame short
      if (state_q == S_END || state_q == S_IDLE)
        stop_q <= 1'b0;
      if (wr_fire && wstrb_q[0]) begin
        case (awaddr_q)
          A_CTRL: begin
            ctrl_q <= wdata_q[`CTRL_W-1:0];
            if (wdata_q[`CTRL_START_BIT])
              start_q <= 1'b1;
            if (wdata_q[`CTRL_STOP_BIT])
              stop_q <= 1'b1;
          end
          A_TXCFG:  txcfg_q     <= wdata_q[5:0];
          A_TXDATA: txbit_q     <= wdata_q[0];
          A_HALF:   half_q[7:0] <= wdata_q[7:0];
          default:  ctrl_q      <= ctrl_q;
        endcase
      end
      if (wr_fire && wstrb_q[1] && awaddr_q == A_HALF)
        half_q[15:8] <= wdata_q[15:8];
    end
  end

  // read channel: one read at a time, data registered with valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          A_CTRL:   s_axi_rdata <= {27'h000_0000, ctrl_q[4:2], 2'h0};
          A_TXCFG:  s_axi_rdata <= {26'h000_0000, txcfg_q};
          A_TXDATA: s_axi_rdata <= {31'h0000_0000, txbit_q};
          A_STATUS: s_axi_rdata <= {25'h000_0000, pol_q, data_sync_q[1], sclk_sync_q[1],
                                    awake_q, state_q};
          A_HALF:   s_axi_rdata <= {16'h0000, half_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // host view of device sleep: enable low past the power-down timer means asleep
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_q <= 32'h0000_0000;
      awake_q   <= 1'b0;
    end else if (ce) begin
      if (state_q == S_SETUP && tick && wait_q == 4'h1) begin
        awake_q   <= 1'b1;
        low_cnt_q <= 32'h0000_0000;
      end else if (enable) begin
        low_cnt_q <= 32'h0000_0000;
      end else if (awake_q) begin
        // limitation: a write of the request bit is not tracked, so software sleep looks like a timeout
        if (low_cnt_q >= SLEEP_LAST)
          awake_q <= 1'b0;
        else
          low_cnt_q <= low_cnt_q + 32'h0000_0001;
      end
    end
  end

  // frame sequencer: wake levels, command byte, extra edge, first bit, stream, end pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q              <= S_IDLE;
      enable               <= 1'b0;
      sclk_o               <= 1'b0;
      sclk_oe_n            <= 1'b0;
      serial_data_pin_o    <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
      pol_q                <= 1'b0;
      shift_q              <= 8'h00;
      bits_q               <= 3'h0;
      wait_q               <= 4'h0;
    end else if (ce) begin
      if (stop_q && state_q != S_IDLE && state_q != S_END) begin
        // enable falls; the device then ignores clock and data and the amplifier mode applies
        enable               <= 1'b0;
        serial_data_pin_oe_n <= 1'b1;
        sclk_oe_n            <= 1'b0;
        sclk_o               <= pol_q;
        wait_q               <= `END_TICKS;
        state_q              <= S_END;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (start_q) begin
              // levels at the rising enable choose sampling edge and clock output when asleep
              if (!awake_q) begin
                pol_q  <= ctrl_q[`CTRL_POL_BIT];
                sclk_o <= ctrl_q[`CTRL_POL_BIT];
              end else begin
                sclk_o <= pol_q;
              end
              sclk_oe_n            <= 1'b0;
              serial_data_pin_o    <= !ctrl_q[`CTRL_CLKOUT_BIT];
              serial_data_pin_oe_n <= 1'b0;
              // code bits first, high bit first, then a5 down to a0
              shift_q <= {`FUNC_TRANSMIT, txcfg_q[5], txcfg_q[4], txcfg_q[3],
                          txcfg_q[2], txcfg_q[1], txcfg_q[0]};
              bits_q  <= 3'h0;
              wait_q  <= `SETUP_TICKS;
              state_q <= S_SETUP;
            end
          end
          S_SETUP: begin
            if (tick) begin
              if (wait_q == 4'h1) begin
                enable  <= 1'b1;
                state_q <= S_CMD;
              end
              wait_q <= wait_q - 4'h1;
            end
          end
          S_CMD: begin
            if (tick) begin
              sclk_o <= !sclk_o;
              if (idle_edge) begin
                // transfer edge: next bit goes out
                serial_data_pin_o <= shift_q[7];
                shift_q           <= {shift_q[6:0], 1'b0};
              end else begin
                // sampling edge: the device takes the bit now
                bits_q <= bits_q + 3'h1;
                if (bits_q == 3'h7)
                  state_q <= S_EXTRA;
              end
            end
          end
          S_EXTRA: begin
            if (tick) begin
              // additional transfer edge moves the device to transmit; first bit set up with it
              sclk_o            <= !sclk_o;
              serial_data_pin_o <= txbit_q;
              state_q           <= S_FIRST;
            end
          end
          S_FIRST: begin
            if (tick) begin
              sclk_o  <= !sclk_o;
              state_q <= S_STREAM;
            end
          end
          S_STREAM: begin
            // the data line follows the register; no clock edges are needed from here
            serial_data_pin_o <= txbit_q;
            if (ctrl_q[`CTRL_REL_BIT])
              sclk_oe_n <= 1'b1;
          end
          S_END: begin
            if (tick) begin
              if (wait_q == 4'h1)
                state_q <= S_IDLE;
              wait_q <= wait_q - 4'h1;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // tx_serial_host
